/* ksc_sequencer_control.sv */
// kr sequencer control register bank on the management port
// --------------------------------------------------------------
// Overview of operation
// - writing one to bit 0 pulses the sequencer restart, then the bit clears.
// - the protocol override in bits 6:4 reaches the sequencer only at the next restart.
// - override codes are 0 none, 1 gigabit, 2 and 3 reserved, 4 10gbase-r, 5 10gbase-kr.
// - bit 1 set disables the negotiation timer, clear enables it.
// - bit 2 set disables the link fault timer, clear enables it.
// - bit 16 advertises fec ability and resets to one only when the strap option is on.
// - bit 17 set makes the fec module report decoding errors to the pcs.
// - every field resets to zero unless a default is given.
// - all registers sit behind one memory-mapped port in one address space.
// - the kr registers occupy word offsets 0xb0 through 0xff.
// - in the four-lane variant the training and fec settings apply to lane 0.
// - the negotiation timeout flag latches and clears when negotiation restarts.
// --------------------------------------------------------------
`timescale 1ns/10ps
`include "ksc_consts.svh"
module ksc_sequencer_control
  import ksc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // generation option: fec ability default after reset
  input wire logic fecDefaultOn,
  // management port
  input wire logic [`KSC_ADDR_W-1:0] address,
  input wire logic write,
  input wire logic read,
  input wire logic [`KSC_DATA_W-1:0] writedata,
  output logic [`KSC_DATA_W-1:0] readdata,
  output logic waitrequest,
  // status from the sequencer
  input wire logic negotiationTimeout,
  input wire logic negotiationRestarted,
  // controls to the sequencer, lane 0 in the four-lane variant
  output logic sequencerRestart,
  output logic [2:0] protocolOverride,
  output logic negotiationTimerOff,
  output logic faultTimerOff,
  output logic fecCapableAdvertise,
  output logic fecErrorReportOn,
  output logic fecRequest
);
  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  logic ctrlHit;
  logic statHit;
  logic ctrlWrite;
  logic [2:0] overrideReg;
  logic timeoutFlag;
  logic strapDone;
  logic [`KSC_DATA_W-1:0] ctrlView;
  logic [`KSC_DATA_W-1:0] statView;
  logic [`KSC_DATA_W-1:0] next_readdata;

  // single address space decode
  function automatic logic hitOf(input logic [`KSC_ADDR_W-1:0] a,
                                 input logic [`KSC_ADDR_W-1:0] want);
    hitOf = (a == want);
  endfunction : hitOf

  assign ctrlHit = hitOf(address, `KSC_ADDR_CTRL);
  assign statHit = hitOf(address, `KSC_ADDR_STAT);
  assign ctrlWrite = write && ctrlHit;

  // control readback, restart reads zero as it self clears
  always_comb begin
    ctrlView = `KSC_ZERO32;
    ctrlView[`KSC_BIT_ANOFF] = negotiationTimerOff;
    ctrlView[`KSC_BIT_LFOFF] = faultTimerOff;
    ctrlView[`KSC_MODE_HI:`KSC_MODE_LO] = overrideReg;
    ctrlView[`KSC_BIT_FECADV] = fecCapableAdvertise;
    ctrlView[`KSC_BIT_FECERR] = fecErrorReportOn;
    ctrlView[`KSC_BIT_REQ] = fecRequest;
  end

  // status readback
  always_comb begin
    statView = `KSC_ZERO32;
    statView[`KSC_BIT_TOUT] = timeoutFlag;
    statView[`KSC_BIT_FECADV] = 1'b1;
    statView[`KSC_BIT_FECERR] = 1'b1;
  end

  // read selection, other kr offsets read zero
  assign next_readdata = !read ? readdata :
                         ctrlHit ? ctrlView :
                         statHit ? statView : `KSC_ZERO32;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // read data and port handshake
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= `KSC_ZERO32;
      waitrequest <= 1'b0;
    end else begin
      readdata <= next_readdata;
      waitrequest <= 1'b0;
    end
  end

  // restart pulse, one cycle, self clearing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sequencerRestart <= 1'b0;
    end else begin
      sequencerRestart <= ctrlWrite && writedata[`KSC_BIT_RESTART];
    end
  end

  // override field, applied to the sequencer on restart only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      overrideReg <= `KSC_ZERO3;
      protocolOverride <= `KSC_ZERO3;
    end else begin
      if (ctrlWrite) begin
        overrideReg <= writedata[`KSC_MODE_HI:`KSC_MODE_LO];
      end
      if (ctrlWrite && writedata[`KSC_BIT_RESTART]) begin
        protocolOverride <= writedata[`KSC_MODE_HI:`KSC_MODE_LO];
      end
    end
  end

  // timer disables and fec bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      negotiationTimerOff <= 1'b0;
      faultTimerOff <= 1'b0;
      fecErrorReportOn <= 1'b0;
      fecRequest <= 1'b0;
    end else if (ctrlWrite) begin
      negotiationTimerOff <= writedata[`KSC_BIT_ANOFF];
      faultTimerOff <= writedata[`KSC_BIT_LFOFF];
      fecErrorReportOn <= writedata[`KSC_BIT_FECERR];
      fecRequest <= writedata[`KSC_BIT_REQ];
    end
  end

  // fec ability: strap sampled on the first clock after reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fecCapableAdvertise <= 1'b0;
      strapDone <= 1'b0;
    end else begin
      strapDone <= 1'b1;
      if (ctrlWrite) begin
        fecCapableAdvertise <= writedata[`KSC_BIT_FECADV];
      end else if (!strapDone) begin
        fecCapableAdvertise <= fecDefaultOn;
      end
    end
  end

  // sticky timeout flag
  ksc_timeout_latch u_tout (
    .clock(clock),
    .resetn(resetn),
    .timeoutEvent(negotiationTimeout),
    .restartEvent(negotiationRestarted),
    .timeoutFlag(timeoutFlag)
  );

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_restart_pulse: assert property (@(posedge clock) disable iff (!resetn)
    sequencerRestart |=> !sequencerRestart || $past(ctrlWrite))
    else $error("restart did not self clear");
  a_restart_cause: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite && writedata[`KSC_BIT_RESTART] |=> sequencerRestart)
    else $error("restart write lost");
  a_override_hold: assert property (@(posedge clock) disable iff (!resetn)
    !(ctrlWrite && writedata[`KSC_BIT_RESTART]) |=>
    $stable(protocolOverride))
    else $error("override moved without restart");
  a_override_load: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite && writedata[`KSC_BIT_RESTART] |=>
    protocolOverride == $past(writedata[`KSC_MODE_HI:`KSC_MODE_LO]))
    else $error("override not loaded on restart");
  // field writes land one cycle after the strobe
  a_antimer_bit: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite |=>
    negotiationTimerOff == $past(writedata[`KSC_BIT_ANOFF]))
    else $error("negotiation timer bit wrong");
  a_lftimer_bit: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite |=> faultTimerOff == $past(writedata[`KSC_BIT_LFOFF]))
    else $error("fault timer bit wrong");
  a_fecerr_bit: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite ##1 !ctrlWrite |->
    fecErrorReportOn == $past(writedata[`KSC_BIT_FECERR]))
    else $error("fec error bit wrong");
  a_fecadv_bit: assert property (@(posedge clock) disable iff (!resetn)
    ctrlWrite |=>
    fecCapableAdvertise == $past(writedata[`KSC_BIT_FECADV]))
    else $error("fec ability bit wrong");
  a_outside_ignored: assert property (@(posedge clock) disable iff (!resetn)
    write && !ctrlHit |=> !sequencerRestart &&
    $stable(negotiationTimerOff) && $stable(faultTimerOff))
    else $error("write outside the control word took effect");
  // read side: no stall, data held between reads, spare bits zero
  a_wait_low: assert property (@(posedge clock) disable iff (!resetn)
    !waitrequest)
    else $error("management port stalled");
  a_readdata_hold: assert property (@(posedge clock) disable iff (!resetn)
    !read |=> $stable(readdata))
    else $error("read data moved without a read");
  a_unused_zero: assert property (@(posedge clock) disable iff (!resetn)
    $past(read && ctrlHit) |->
    (readdata & ~(`KSC_CTRL_RD_USED)) == `KSC_ZERO32)
    else $error("unassigned bits read nonzero");
  a_read_flag: assert property (@(posedge clock) disable iff (!resetn)
    read && statHit |=> readdata[`KSC_BIT_TOUT] == $past(timeoutFlag))
    else $error("timeout flag readback wrong");
  c_restart: cover property (@(posedge clock) disable iff (!resetn)
    sequencerRestart);
  c_force_kr: cover property (@(posedge clock) disable iff (!resetn)
    protocolOverride == KSC_TENG_KR);
  c_timeout: cover property (@(posedge clock) disable iff (!resetn)
    timeoutFlag ##1 !timeoutFlag);
  c_override_held: cover property (@(posedge clock) disable iff (!resetn)
    ctrlWrite && !writedata[`KSC_BIT_RESTART]);
endmodule : ksc_sequencer_control

/* ksc_consts.svh */
// constants for the kr sequencer control register bank
`ifndef KSC_CONSTS_SVH
`define KSC_CONSTS_SVH
`define KSC_ADDR_W 8
`define KSC_DATA_W 32
`define KSC_ADDR_CTRL 8'hb0
`define KSC_ADDR_STAT 8'hb1
`define KSC_ADDR_LO 8'hb0
`define KSC_ADDR_HI 8'hff
`define KSC_BIT_RESTART 0
`define KSC_BIT_ANOFF 1
`define KSC_BIT_LFOFF 2
`define KSC_MODE_LO 4
`define KSC_MODE_HI 6
`define KSC_BIT_FECADV 16
`define KSC_BIT_FECERR 17
`define KSC_BIT_REQ 18
`define KSC_BIT_TOUT 1
`define KSC_CTRL_RD_USED 32'h0007_0076
`define KSC_ZERO32 32'h0000_0000
`define KSC_ZERO3 3'h0
`endif

/* ksc_pkg.sv */
// types for the kr sequencer control register bank
package ksc_pkg;
  typedef enum logic [2:0] {
    KSC_NO_FORCE = 3'h0,
    KSC_GIGE = 3'h1,
    KSC_RSV2 = 3'h2,
    KSC_RSV3 = 3'h3,
    KSC_TENG_R = 3'h4,
    KSC_TENG_KR = 3'h5
  } ksc_proto_t;
endpackage : ksc_pkg

/* ksc_timeout_latch.sv */
// sticky negotiation timeout flag
`timescale 1ns/10ps
`include "ksc_consts.svh"
module ksc_timeout_latch (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // events
  input wire logic timeoutEvent,
  input wire logic restartEvent,
  // flag
  output logic timeoutFlag
);
  logic next_timeoutFlag;

  // set wins over a simultaneous restart so the event is not lost
  assign next_timeoutFlag = timeoutEvent ? 1'b1 :
                            (restartEvent ? 1'b0 : timeoutFlag);

  // flag register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timeoutFlag <= 1'b0;
    end else begin
      timeoutFlag <= next_timeoutFlag;
    end
  end

  a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    timeoutFlag && !restartEvent |=> timeoutFlag)
    else $error("timeout flag dropped without restart");
  a_flag_set: assert property (@(posedge clock) disable iff (!resetn)
    timeoutEvent |=> timeoutFlag)
    else $error("timeout flag not set by event");
endmodule : ksc_timeout_latch

/* ksc_sequencer_control_tb_top.sv */
// self-checking testbench for the kr sequencer control register bank
`timescale 1ns/10ps
`include "ksc_consts.svh"
module ksc_sequencer_control_tb_top;
  import ksc_pkg::*;
  // --------------------------------------------------------------
  // signals and instance
  // --------------------------------------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic fecDefaultOn = 1'b0;
  logic [7:0] address = 8'h00;
  logic write = 1'b0;
  logic read = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic negotiationTimeout = 1'b0;
  logic negotiationRestarted = 1'b0;
  logic sequencerRestart;
  logic [2:0] protocolOverride;
  logic negotiationTimerOff;
  logic faultTimerOff;
  logic fecCapableAdvertise;
  logic fecErrorReportOn;
  logic fecRequest;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rv;

  ksc_sequencer_control i_dut (
    .clock(clock), .resetn(resetn), .fecDefaultOn(fecDefaultOn),
    .address(address), .write(write), .read(read),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .negotiationTimeout(negotiationTimeout),
    .negotiationRestarted(negotiationRestarted),
    .sequencerRestart(sequencerRestart),
    .protocolOverride(protocolOverride),
    .negotiationTimerOff(negotiationTimerOff),
    .faultTimerOff(faultTimerOff),
    .fecCapableAdvertise(fecCapableAdvertise),
    .fecErrorReportOn(fecErrorReportOn), .fecRequest(fecRequest)
  );

  // 50 mhz clock
  always #10 clock = ~clock;

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  // verdict and end of run
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // compare one value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one write cycle; outputs are settled when it returns
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    address = a;
    writedata = d;
    write = 1'b1;
    @(negedge clock);
    write = 1'b0;
  endtask : wr

  // one read cycle; data is taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clock);
    address = a;
    read = 1'b1;
    @(negedge clock);
    read = 1'b0;
    d = readdata;
  endtask : rd

  // reset held for 12 cycles with the given fec strap
  task automatic doRst(input logic fec);
    resetn = 1'b0;
    fecDefaultOn = fec;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
  endtask : doRst

  // control outputs gathered in register order
  function automatic logic [31:0] ctl();
    return {13'h0, fecRequest, fecErrorReportOn, fecCapableAdvertise, 9'h0,
      protocolOverride, 1'b0, faultTimerOff, negotiationTimerOff,
      sequencerRestart};
  endfunction : ctl

  // --------------------------------------------------------------
  // hang guard
  // --------------------------------------------------------------
  initial begin
    #200000;
    num_errors++;
    test_done();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    doRst(1'b0);
    chk("ctl rst", 32'h0, ctl());
    chk("wait", 32'h0, {31'h0, waitrequest});
    rd(8'hb0, rv);
    chk("b0 rst", 32'h0, rv);
    rd(8'hb1, rv);
    chk("b1 rst", 32'h0003_0000, rv);
    // restart with override 5 and fault timer off
    wr(8'hb0, 32'h0000_0055);
    chk("ctl 55", 32'h0000_0055, ctl());
    @(negedge clock);
    chk("ctl after", 32'h0000_0054, ctl());
    rd(8'hb0, rv);
    chk("b0 55", 32'h0000_0054, rv);
    // override change without restart is held back
    wr(8'hb0, 32'h0002_0012);
    chk("ctl 12", 32'h0002_0052, ctl());
    rd(8'hb0, rv);
    chk("b0 12", 32'h0002_0012, rv);
    // every override code applied with restart
    for (int c = 0; c < 6; c++) begin
      wr(8'hb0, {25'h0, c[2:0], 4'h1});
      chk("override", {29'h0, c[2:0]}, {29'h0, protocolOverride});
    end
    // all ones: unassigned bits stay zero
    wr(8'hb0, 32'hffff_ffff);
    chk("ctl ff", 32'h0007_0077, ctl());
    rd(8'hb0, rv);
    chk("b0 ff", 32'h0007_0076, rv);
    // a write to the read-only status word leaves control alone
    wr(8'hb1, 32'h0000_0000);
    chk("ctl b1", 32'h0007_0076, ctl());
    // reads outside the bank return zero
    rd(8'haf, rv);
    chk("rd af", 32'h0, rv);
    // negotiation timer bit cleared, fault timer bit left set
    wr(8'hb0, 32'h0000_0004);
    chk("ctl 04", 32'h0000_0074, ctl());
    // negotiation timer turned off by read-modify-write
    rd(8'hb0, rv);
    chk("b0 04", 32'h0000_0004, rv);
    wr(8'hb0, rv | 32'h0000_0002);
    chk("ctl rmw", 32'h0000_0076, ctl());
    // negotiation timeout flag latches until restart
    @(negedge clock);
    negotiationTimeout = 1'b1;
    @(negedge clock);
    negotiationTimeout = 1'b0;
    repeat (3) @(negedge clock);
    rd(8'hb1, rv);
    chk("flag set", 32'h0003_0002, rv);
    // timer off: software restarts the stuck negotiation itself
    rd(8'hb0, rv);
    wr(8'hb0, rv | 32'h0000_0001);
    chk("ctl unstick", 32'h0000_0007, ctl());
    @(negedge clock);
    negotiationRestarted = 1'b1;
    @(negedge clock);
    negotiationRestarted = 1'b0;
    rd(8'hb1, rv);
    chk("flag clr", 32'h0003_0000, rv);
    // reset again with the fec strap on
    doRst(1'b1);
    chk("ctl fec", 32'h0001_0000, ctl());
    rd(8'hb0, rv);
    chk("b0 fec", 32'h0001_0000, rv);
    test_done();
  end
endmodule : ksc_sequencer_control_tb_top
